// File: core/sdms_sequencer.sv
`default_nettype none
module sdms_sequencer #(
	parameter int SF_UNIT_CYCLES = 16,
	parameter logic [3:0] TEMP_SENSOR_CHANNEL = 4'hF
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	output logic [7:0] SFR_RDATA,
	input wire logic WAKE,
	output logic PRI_RESET,
	output logic AUX_RESET,
	output logic PRI_MOD_RUN,
	output logic AUX_MOD_RUN,
	output logic PRI_FILT_HOLD,
	output logic AUX_FILT_HOLD,
	output logic INPUT_SHORT,
	output logic INPUT_REF,
	output logic [1:0] PRI_REF_SEL,
	output logic [1:0] AUX_REF_SEL,
	output logic [3:0] PRI_CHANNEL,
	output logic [3:0] AUX_CHANNEL,
	output logic [7:0] PRI_CTRL,
	output logic CHOP_OFF,
	output logic PRI_RESULT_LOAD,
	output logic AUX_RESULT_LOAD,
	output logic PRI_COEF_WRITE,
	output logic AUX_COEF_WRITE,
	output logic [1:0] CAL_KIND
);
	// ------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------
	function automatic logic is_cal(input logic [2:0] m);
		return m[2];
	endfunction

	function automatic sdms_pkg::sdms_state_type state_for(input logic [2:0] m);
		case (m)
			sdms_pkg::MODE_PDOWN: return sdms_pkg::ST_OFF;
			sdms_pkg::MODE_IDLE: return sdms_pkg::ST_IDLE;
			sdms_pkg::MODE_SINGLE, sdms_pkg::MODE_CONT: return sdms_pkg::ST_CONV;
			default: return sdms_pkg::ST_CAL;
		endcase
	endfunction

	logic [7:0] mode_q, mode_d, pri_ctrl_q, pri_ctrl_d, chref_q, chref_d;
	logic [7:0] aux_cfg_q, aux_cfg_d, filt_q, filt_d, rdata_q, rdata_d, status_rd;
	logic pd_q, pd_d, primary_ready_flag_q, primary_ready_flag_d, aux_ready_flag_q, aux_ready_flag_d, aux_error_flag_q, aux_error_flag_d;
	logic rst_pri_q, rst_pri_d, rst_aux_q, rst_aux_d, ld_pri_q, ld_pri_d, ld_aux_q, ld_aux_d;
	logic coef_pri_q, coef_pri_d, coef_aux_q, coef_aux_d;
	logic [2:0] cal_cnt_q, cal_cnt_d, cal_last;
	logic [1:0] aux_wait_q, aux_wait_d;
	logic [2:0] wk_q, wk_d;
	sdms_pkg::sdms_state_type state_q, state_d;
	logic wr_mode, wr_status, wr_pri_ctrl, wr_chref, wr_aux, wr_filt, wr_power;
	logic wake_seen, aux_only_write, reset_both, reset_aux, pri_conv, aux_is_temp;
	logic cal_done, tick, timer_restart, timer_run, active, pri_en, aux_en;
	logic [2:0] mode_f, wmode_f;

	assign wr_mode = SFR_WR && SFR_ADDR == sdms_pkg::ADDR_MODE;
	assign wr_status = SFR_WR && SFR_ADDR == sdms_pkg::ADDR_STATUS;
	assign wr_pri_ctrl = SFR_WR && SFR_ADDR == sdms_pkg::ADDR_PRI_CTRL;
	assign wr_chref = SFR_WR && SFR_ADDR == sdms_pkg::ADDR_PRI_CHREF;
	assign wr_aux = SFR_WR && SFR_ADDR == sdms_pkg::ADDR_AUX_CFG;
	assign wr_filt = SFR_WR && SFR_ADDR == sdms_pkg::ADDR_FILTER;
	assign wr_power = SFR_WR && SFR_ADDR == sdms_pkg::ADDR_POWER;

	assign mode_f = mode_q[sdms_pkg::MODE_LSB +: sdms_pkg::MODE_W];
	assign wmode_f = SFR_WDATA[sdms_pkg::MODE_LSB +: sdms_pkg::MODE_W];
	assign pri_en = mode_q[sdms_pkg::MODE_PRI_EN_BIT];
	assign aux_en = mode_q[sdms_pkg::MODE_AUX_EN_BIT];

	// Only the second and third stages are looked at
	assign wake_seen = pd_q && wk_q[1] && wk_q[2];
	// Enabling only the aux with mode and primary untouched spares the primary
	assign aux_only_write = wr_mode && wmode_f == mode_f
		&& SFR_WDATA[sdms_pkg::MODE_AUX_EN_BIT] && !aux_en
		&& SFR_WDATA[sdms_pkg::MODE_PRI_EN_BIT] == pri_en
		&& SFR_WDATA[sdms_pkg::MODE_CHOP_OFF_BIT] == mode_q[sdms_pkg::MODE_CHOP_OFF_BIT];
	assign reset_both = (wr_mode && !aux_only_write)
		|| ((wr_pri_ctrl || wr_chref) && pri_en)
		|| wake_seen;
	assign reset_aux = !reset_both && (wr_aux || aux_only_write);
	assign pri_conv = state_q == sdms_pkg::ST_CONV && pri_en && !pd_q;
	assign aux_is_temp = aux_cfg_q[sdms_pkg::CHAN_LSB +: sdms_pkg::CHAN_W] == TEMP_SENSOR_CHANNEL;
	assign cal_last = (mode_q[sdms_pkg::MODE_CHOP_OFF_BIT] ? sdms_pkg::CAL_TICKS_CHOP_OFF :
		sdms_pkg::CAL_TICKS_CHOP_ON) - 3'h1;
	assign cal_done = cal_cnt_q == cal_last;
	assign timer_run = !pd_q && (state_q == sdms_pkg::ST_CONV || state_q == sdms_pkg::ST_CAL);

	sdms_rate_timer #(
		.UNIT_CYCLES(SF_UNIT_CYCLES)
	) u_timer (
		.clk(CLK),
		.rst_n(RST_N),
		.restart(timer_restart),
		.run(timer_run),
		.sf_word(filt_q),
		.chop_off(mode_q[sdms_pkg::MODE_CHOP_OFF_BIT]),
		.tick(tick)
	);

	// ------------------------------------------------------------
	// Wake pin synchroniser
	// ------------------------------------------------------------
	always_comb begin
		wk_d = {wk_q[1:0], WAKE};
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wk_q <= 3'h0;
		end else begin
			wk_q <= wk_d;
		end
	end

	// ------------------------------------------------------------
	// Registers and sequencing
	// ------------------------------------------------------------
	always_comb begin
		mode_d = mode_q;
		pri_ctrl_d = wr_pri_ctrl ? SFR_WDATA : pri_ctrl_q;
		chref_d = wr_chref ? SFR_WDATA : chref_q;
		aux_cfg_d = wr_aux ? SFR_WDATA : aux_cfg_q;
		filt_d = wr_filt ? SFR_WDATA : filt_q;
		pd_d = pd_q;
		primary_ready_flag_d = primary_ready_flag_q;
		aux_ready_flag_d = aux_ready_flag_q;
		aux_error_flag_d = aux_error_flag_q;
		state_d = state_q;
		cal_cnt_d = cal_cnt_q;
		aux_wait_d = aux_wait_q;
		rst_pri_d = 1'h0;
		rst_aux_d = 1'h0;
		ld_pri_d = 1'h0;
		ld_aux_d = 1'h0;
		coef_pri_d = 1'h0;
		coef_aux_d = 1'h0;
		timer_restart = 1'h0;
		rdata_d = rdata_q;
		status_rd = sdms_pkg::RD_ZERO;
		status_rd[sdms_pkg::STAT_PRIMARY_READY_FLAG_BIT] = primary_ready_flag_q;
		status_rd[sdms_pkg::STAT_AUX_READY_FLAG_BIT] = aux_ready_flag_q;
		status_rd[sdms_pkg::STAT_AUX_ERROR_FLAG_BIT] = aux_error_flag_q;
		if (wr_mode) begin
			mode_d = SFR_WDATA;
		end
		if (wr_power) begin
			pd_d = SFR_WDATA[sdms_pkg::POWER_PD_BIT];
		end
		if (wake_seen) begin
			pd_d = 1'h0;
		end
		// Clears go first so that a hardware set in the same cycle wins
		if (wr_status) begin
			primary_ready_flag_d = primary_ready_flag_q & ~SFR_WDATA[sdms_pkg::STAT_PRIMARY_READY_FLAG_BIT];
			aux_ready_flag_d = aux_ready_flag_q & ~SFR_WDATA[sdms_pkg::STAT_AUX_READY_FLAG_BIT];
			aux_error_flag_d = aux_error_flag_q & ~SFR_WDATA[sdms_pkg::STAT_AUX_ERROR_FLAG_BIT];
		end
		if (reset_both) begin
			rst_pri_d = 1'h1;
			rst_aux_d = 1'h1;
			timer_restart = 1'h1;
			state_d = state_for(mode_d[sdms_pkg::MODE_LSB +: sdms_pkg::MODE_W]);
			cal_cnt_d = 3'h0;
			aux_wait_d = 2'h0;
			if (is_cal(mode_d[sdms_pkg::MODE_LSB +: sdms_pkg::MODE_W])) begin
				primary_ready_flag_d = 1'h0;
				aux_ready_flag_d = 1'h0;
				aux_error_flag_d = 1'h0;
			end
		end else if (reset_aux) begin
			rst_aux_d = 1'h1;
			if (pri_conv) begin
				aux_wait_d = sdms_pkg::AUX_ALIGN_OUTPUTS;
			end else begin
				aux_wait_d = 2'h0;
				timer_restart = 1'h1;
			end
		end
		// A tick still counts for the primary when only the aux restarts
		if (!reset_both && tick && !pd_q) begin
			case (state_q)
				sdms_pkg::ST_CONV: begin
					if (pri_en) begin
						ld_pri_d = 1'h1;
						primary_ready_flag_d = 1'h1;
					end
					if (aux_en && !reset_aux) begin
						if (aux_wait_q != 2'h0) begin
							aux_wait_d = aux_wait_q - 2'h1;
						end else begin
							ld_aux_d = 1'h1;
							aux_ready_flag_d = 1'h1;
						end
					end
					if (mode_f == sdms_pkg::MODE_SINGLE) begin
						mode_d[sdms_pkg::MODE_LSB +: sdms_pkg::MODE_W] = sdms_pkg::MODE_PDOWN;
						state_d = sdms_pkg::ST_OFF;
					end
				end
				sdms_pkg::ST_CAL: begin
					cal_cnt_d = cal_cnt_q + 3'h1;
					if (cal_done) begin
						cal_cnt_d = 3'h0;
						state_d = sdms_pkg::ST_OFF;
						mode_d[sdms_pkg::MODE_LSB +: sdms_pkg::MODE_W] = sdms_pkg::MODE_PDOWN;
						if (pri_en) begin
							coef_pri_d = 1'h1;
							primary_ready_flag_d = 1'h1;
						end
						if (aux_en) begin
							aux_ready_flag_d = 1'h1;
							if (aux_is_temp) begin
								aux_error_flag_d = 1'h1;
							end else begin
								coef_aux_d = 1'h1;
							end
						end
					end
				end
				default: begin
				end
			endcase
		end
		if (SFR_RD) begin
			case (SFR_ADDR)
				sdms_pkg::ADDR_MODE: rdata_d = mode_q;
				sdms_pkg::ADDR_STATUS: rdata_d = status_rd;
				sdms_pkg::ADDR_PRI_CTRL: rdata_d = pri_ctrl_q;
				sdms_pkg::ADDR_PRI_CHREF: rdata_d = chref_q;
				sdms_pkg::ADDR_AUX_CFG: rdata_d = aux_cfg_q;
				sdms_pkg::ADDR_FILTER: rdata_d = filt_q;
				sdms_pkg::ADDR_POWER: begin
					rdata_d = sdms_pkg::RD_ZERO;
					rdata_d[sdms_pkg::POWER_PD_BIT] = pd_q;
				end
				default: rdata_d = sdms_pkg::RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mode_q <= sdms_pkg::RST_MODE;
			pri_ctrl_q <= sdms_pkg::RST_PRI_CTRL;
			chref_q <= sdms_pkg::RST_PRI_CHREF;
			aux_cfg_q <= sdms_pkg::RST_AUX_CFG;
			filt_q <= sdms_pkg::RST_FILTER;
			rdata_q <= sdms_pkg::RD_ZERO;
			{pd_q, primary_ready_flag_q, aux_ready_flag_q, aux_error_flag_q} <= 4'h0;
			{rst_pri_q, rst_aux_q, ld_pri_q, ld_aux_q, coef_pri_q, coef_aux_q} <= 6'h00;
			state_q <= sdms_pkg::ST_OFF;
			cal_cnt_q <= 3'h0;
			aux_wait_q <= 2'h0;
		end else begin
			mode_q <= mode_d;
			pri_ctrl_q <= pri_ctrl_d;
			chref_q <= chref_d;
			aux_cfg_q <= aux_cfg_d;
			filt_q <= filt_d;
			rdata_q <= rdata_d;
			{pd_q, primary_ready_flag_q, aux_ready_flag_q, aux_error_flag_q} <= {pd_d, primary_ready_flag_d, aux_ready_flag_d, aux_error_flag_d};
			{rst_pri_q, rst_aux_q, ld_pri_q, ld_aux_q} <= {rst_pri_d, rst_aux_d, ld_pri_d, ld_aux_d};
			{coef_pri_q, coef_aux_q} <= {coef_pri_d, coef_aux_d};
			state_q <= state_d;
			cal_cnt_q <= cal_cnt_d;
			aux_wait_q <= aux_wait_d;
		end
	end

	// ------------------------------------------------------------
	// Converter controls
	// ------------------------------------------------------------
	assign active = !pd_q && state_q != sdms_pkg::ST_OFF;
	assign PRI_MOD_RUN = active && pri_en;
	assign AUX_MOD_RUN = active && aux_en;
	assign PRI_FILT_HOLD = state_q == sdms_pkg::ST_IDLE || rst_pri_q;
	assign AUX_FILT_HOLD = state_q == sdms_pkg::ST_IDLE || rst_aux_q;
	assign INPUT_SHORT = active && state_q == sdms_pkg::ST_CAL && mode_f == sdms_pkg::MODE_ZS_INT;
	assign INPUT_REF = active && state_q == sdms_pkg::ST_CAL && mode_f == sdms_pkg::MODE_FS_INT;
	assign PRI_REF_SEL = chref_q[sdms_pkg::CHREF_REF_LSB +: sdms_pkg::REF_W];
	assign AUX_REF_SEL = aux_cfg_q[sdms_pkg::AUX_REF_LSB +: sdms_pkg::REF_W];
	assign PRI_CHANNEL = chref_q[sdms_pkg::CHAN_LSB +: sdms_pkg::CHAN_W];
	assign AUX_CHANNEL = aux_cfg_q[sdms_pkg::CHAN_LSB +: sdms_pkg::CHAN_W];
	assign PRI_CTRL = pri_ctrl_q;
	assign CHOP_OFF = mode_q[sdms_pkg::MODE_CHOP_OFF_BIT];
	assign CAL_KIND = mode_q[sdms_pkg::MODE_LSB +: sdms_pkg::KIND_W];
	assign PRI_RESET = rst_pri_q;
	assign AUX_RESET = rst_aux_q;
	assign PRI_RESULT_LOAD = ld_pri_q;
	assign AUX_RESULT_LOAD = ld_aux_q;
	assign PRI_COEF_WRITE = coef_pri_q;
	assign AUX_COEF_WRITE = coef_aux_q;
	assign SFR_RDATA = rdata_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_cont_load;
		@(posedge CLK) disable iff (!RST_N)
		tick && !pd_q && !reset_both && state_q == sdms_pkg::ST_CONV && pri_en
		|=> PRI_RESULT_LOAD && primary_ready_flag_q;
	endproperty
	a_cont_load: assert property (p_cont_load) else $error("no primary load on tick");
	property p_cal_inputs;
		@(posedge CLK) disable iff (!RST_N)
		active && state_q == sdms_pkg::ST_CAL |-> INPUT_SHORT == (mode_f == sdms_pkg::MODE_ZS_INT)
		&& INPUT_REF == (mode_f == sdms_pkg::MODE_FS_INT);
	endproperty
	a_cal_inputs: assert property (p_cal_inputs) else $error("cal input switch wrong");
	property p_mode_reset;
		@(posedge CLK) disable iff (!RST_N)
		wr_mode && !aux_only_write |=> PRI_RESET && AUX_RESET
		##1 (!PRI_RESET || $past(reset_both));
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("mode write did not reset");
	property p_pri_cfg_reset;
		@(posedge CLK) disable iff (!RST_N)
		(wr_pri_ctrl || wr_chref) && pri_en |=> PRI_RESET && AUX_RESET;
	endproperty
	a_pri_cfg_reset: assert property (p_pri_cfg_reset) else $error("primary cfg no reset");
	property p_aux_reset;
		@(posedge CLK) disable iff (!RST_N)
		wr_aux && !reset_both |=> AUX_RESET && !PRI_RESET
		&& PRI_RESULT_LOAD == ($past(tick) && $past(pri_conv));
	endproperty
	a_aux_reset: assert property (p_aux_reset) else $error("aux cfg reset wrong");
	property p_aux_align;
		@(posedge CLK) disable iff (!RST_N)
		reset_aux && pri_conv |=> aux_wait_q == sdms_pkg::AUX_ALIGN_OUTPUTS && !AUX_RESULT_LOAD;
	endproperty
	a_aux_align: assert property (p_aux_align) else $error("aux not aligned");
	property p_aux_now;
		@(posedge CLK) disable iff (!RST_N)
		reset_aux && !pri_conv |=> aux_wait_q == 2'h0;
	endproperty
	a_aux_now: assert property (p_aux_now) else $error("aux waited needlessly");
	property p_pd_keep;
		@(posedge CLK) disable iff (!RST_N)
		pd_q && !SFR_WR |=> mode_q == $past(mode_q) && !PRI_RESULT_LOAD;
	endproperty
	a_pd_keep: assert property (p_pd_keep) else $error("mode lost in power-down");
	property p_cal_clear;
		@(posedge CLK) disable iff (!RST_N)
		wr_mode && is_cal(wmode_f) |=> !primary_ready_flag_q && !aux_ready_flag_q && state_q == sdms_pkg::ST_CAL;
	endproperty
	a_cal_clear: assert property (p_cal_clear) else $error("cal start flags wrong");
	property p_cal_end;
		@(posedge CLK) disable iff (!RST_N)
		tick && !pd_q && !reset_both && !reset_aux && state_q == sdms_pkg::ST_CAL && cal_done
		|=> mode_f == sdms_pkg::MODE_PDOWN && PRI_COEF_WRITE == $past(pri_en)
		&& (cal_last == 3'h1 || cal_last == 3'h3);
	endproperty
	a_cal_end: assert property (p_cal_end) else $error("cal end wrong");
	property p_temp_fail;
		@(posedge CLK) disable iff (!RST_N)
		tick && !pd_q && !reset_both && !reset_aux && state_q == sdms_pkg::ST_CAL && cal_done
		&& aux_en && aux_is_temp |=> aux_error_flag_q && aux_ready_flag_q && !AUX_COEF_WRITE;
	endproperty
	a_temp_fail: assert property (p_temp_fail) else $error("temp cal did not fail");
	property p_idle;
		@(posedge CLK) disable iff (!RST_N)
		state_q == sdms_pkg::ST_IDLE && !pd_q && pri_en |-> PRI_FILT_HOLD && PRI_MOD_RUN;
	endproperty
	a_idle: assert property (p_idle) else $error("idle controls wrong");
	property p_reset_mode;
		@(posedge CLK) disable iff (!RST_N)
		!$past(RST_N) |-> mode_f == sdms_pkg::MODE_PDOWN && state_q == sdms_pkg::ST_OFF;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("reset mode not zero");
	property p_single;
		@(posedge CLK) disable iff (!RST_N)
		tick && !pd_q && !reset_both && !reset_aux && state_q == sdms_pkg::ST_CONV
		&& mode_f == sdms_pkg::MODE_SINGLE |=> mode_f == sdms_pkg::MODE_PDOWN ##1 !PRI_RESULT_LOAD;
	endproperty
	a_single: assert property (p_single) else $error("single did not stop");
endmodule
`default_nettype wire

// File: core/sdms_pkg.sv
`default_nettype none
package sdms_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE = 8'hD1;
	localparam logic [7:0] ADDR_STATUS = 8'hD8;
	localparam logic [7:0] ADDR_PRI_CTRL = 8'hD2;
	localparam logic [7:0] ADDR_PRI_CHREF = 8'hE6;
	localparam logic [7:0] ADDR_AUX_CFG = 8'hE1;
	localparam logic [7:0] ADDR_FILTER = 8'hE3;
	localparam logic [7:0] ADDR_POWER = 8'hC7;

	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_PRI_CTRL = 8'h07;
	localparam logic [7:0] RST_PRI_CHREF = 8'h00;
	localparam logic [7:0] RST_AUX_CFG = 8'h00;
	localparam logic [7:0] RST_FILTER = 8'hFF;
	localparam logic [7:0] RD_ZERO = 8'h00;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 3;
	localparam int MODE_CHOP_OFF_BIT = 3;
	localparam int MODE_AUX_EN_BIT = 4;
	localparam int MODE_PRI_EN_BIT = 5;
	localparam int STAT_PRIMARY_READY_FLAG_BIT = 7;
	localparam int STAT_AUX_READY_FLAG_BIT = 6;
	localparam int STAT_AUX_ERROR_FLAG_BIT = 4;
	localparam int POWER_PD_BIT = 1;
	localparam int CHREF_REF_LSB = 6;
	localparam int AUX_REF_LSB = 4;
	localparam int CHAN_LSB = 0;
	localparam int REF_W = 2;
	localparam int CHAN_W = 4;
	localparam int KIND_W = 2;

	// ------------------------------------------------------------
	// Modes, states, timing
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_PDOWN = 3'h0,
		MODE_IDLE = 3'h1,
		MODE_SINGLE = 3'h2,
		MODE_CONT = 3'h3,
		MODE_ZS_INT = 3'h4,
		MODE_FS_INT = 3'h5,
		MODE_ZS_SYS = 3'h6,
		MODE_FS_SYS = 3'h7
	} sdms_mode_type;

	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_IDLE = 4'h2,
		ST_CONV = 4'h4,
		ST_CAL = 4'h8
	} sdms_state_type;

	localparam logic [2:0] CAL_TICKS_CHOP_ON = 3'h2;
	localparam logic [2:0] CAL_TICKS_CHOP_OFF = 3'h4;
	localparam logic [1:0] AUX_ALIGN_OUTPUTS = 2'h3;
	localparam logic [9:0] CHOP_ON_SLOWDOWN = 10'h003;
endpackage
`default_nettype wire

// File: core/sdms_rate_timer.sv
`default_nettype none
module sdms_rate_timer #(
	parameter int UNIT_CYCLES = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic run,
	input wire logic [7:0] sf_word,
	input wire logic chop_off,
	output logic tick
);
	// ------------------------------------------------------------
	// Update period: (sf+1) units, three times longer with chopping
	// ------------------------------------------------------------
	localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYCLES - 1);

	logic [15:0] unit_q, unit_d;
	logic [9:0] slot_q, slot_d, slot_last;
	logic tick_q, tick_d;

	always_comb begin
		slot_last = chop_off ? {2'h0, sf_word} :
			{2'h0, sf_word} * sdms_pkg::CHOP_ON_SLOWDOWN + sdms_pkg::CHOP_ON_SLOWDOWN - 10'h001;
		unit_d = unit_q;
		slot_d = slot_q;
		tick_d = 1'h0;
		if (restart || !run) begin
			unit_d = 16'h0000;
			slot_d = 10'h000;
		end else if (unit_q >= UNIT_LAST) begin
			unit_d = 16'h0000;
			if (slot_q >= slot_last) begin
				slot_d = 10'h000;
				tick_d = 1'h1;
			end else begin
				slot_d = slot_q + 10'h001;
			end
		end else begin
			unit_d = unit_q + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			unit_q <= 16'h0000;
			slot_q <= 10'h000;
			tick_q <= 1'h0;
		end else begin
			unit_q <= unit_d;
			slot_q <= slot_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule
`default_nettype wire

// File: verification/sdms_core_model.sv
`default_nettype none
// ----------------------------------------
// Core side of the register bus
// ----------------------------------------
module sdms_core_model (
	input wire logic clk,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	// One strobed cycle; a released bus is scrambled so stale values never look valid
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		xfer(1'b0, a, 8'h00);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// File: verification/sigma_delta_adc_mode_sequencer_tb_top.sv
`default_nettype none
module sigma_delta_adc_mode_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, wake, wr, rd, pri_reset, aux_reset, pri_mod_run, pri_filt_hold;
	logic input_short, input_ref, pri_load, aux_load, pri_coef, aux_coef;
	logic aux_mod_run, aux_filt_hold, chop_off;
	logic [7:0] addr, wdata, rdata, pri_ctrl;
	logic [1:0] pri_ref_sel, cal_kind, aux_ref_sel;
	logic [3:0] pri_channel, aux_channel;
	wire logic [3:0] pulses;
	int n_errors = 0;
	int compares = 0;
	assign pulses = {aux_coef, pri_coef, aux_load, pri_load};
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Short filter unit keeps update periods to a few clocks
	sdms_sequencer #(.SF_UNIT_CYCLES(1), .TEMP_SENSOR_CHANNEL(4'hF)) u_dut (
		.CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WR(wr),
		.SFR_RD(rd), .SFR_RDATA(rdata), .WAKE(wake), .PRI_RESET(pri_reset),
		.AUX_RESET(aux_reset), .PRI_MOD_RUN(pri_mod_run), .AUX_MOD_RUN(aux_mod_run),
		.PRI_FILT_HOLD(pri_filt_hold), .AUX_FILT_HOLD(aux_filt_hold),
		.INPUT_SHORT(input_short), .INPUT_REF(input_ref), .PRI_REF_SEL(pri_ref_sel),
		.AUX_REF_SEL(aux_ref_sel), .PRI_CHANNEL(pri_channel), .AUX_CHANNEL(aux_channel),
		.PRI_CTRL(pri_ctrl), .CHOP_OFF(chop_off), .PRI_RESULT_LOAD(pri_load),
		.AUX_RESULT_LOAD(aux_load), .PRI_COEF_WRITE(pri_coef), .AUX_COEF_WRITE(aux_coef),
		.CAL_KIND(cal_kind));
	sdms_core_model u_core (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wait_pulse(input int sel, input int lim, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				n_errors++;
				$display("unexpected pulse wait: expected 1, seen 0");
				wrap_up();
			end
		end while (pulses[sel] !== 1'b1);
	endtask
	task automatic wr_rst(input logic [7:0] a, input logic [7:0] d, input logic ep,
		input logic ea);
		u_core.xfer(1'b1, a, d);
		chk("resets", {6'h0, ep, ea}, {6'h0, pri_reset, aux_reset});
		@(negedge clk);
		chk("reset pulse end", 8'h00, {6'h0, pri_reset, aux_reset});
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_resets();
		logic [7:0] d;
		u_core.read(8'hD1, d);
		chk("mode", 8'h00, d);
		u_core.read(8'h00, d);
		chk("unmapped", 8'h00, d);
		u_core.read(8'hD2, d);
		chk("primary control", 8'h07, d);
		chk("modulator run", 8'h00, {6'h0, aux_mod_run, pri_mod_run});
		wr_rst(8'hD1, 8'h21, 1'b1, 1'b1);
		wr_rst(8'hD1, 8'h31, 1'b0, 1'b1);
		chk("idle hold and run", 8'h03, {6'h0, pri_filt_hold, pri_mod_run});
		chk("aux idle hold and run", 8'h03, {6'h0, aux_filt_hold, aux_mod_run});
		wr_rst(8'hD1, 8'h31, 1'b1, 1'b1);
		wr_rst(8'hD2, 8'h05, 1'b1, 1'b1);
		chk("primary control out", 8'h05, pri_ctrl);
		wr_rst(8'hE1, 8'h00, 1'b0, 1'b1);
	endtask
	task automatic t_convert();
		logic [7:0] d;
		int n;
		u_core.xfer(1'b1, 8'hE3, 8'h03);
		u_core.xfer(1'b1, 8'hD1, 8'h2A);
		wait_pulse(0, 20, n);
		u_core.read(8'hD1, d);
		chk("mode after single", 8'h28, d);
		u_core.read(8'hD8, d);
		chk("primary ready", 8'h80, d & 8'h80);
		u_core.xfer(1'b1, 8'hD1, 8'h2B);
		wait_pulse(0, 20, n);
		wait_pulse(0, 20, n);
		chk("update period", 8'h04, n[7:0]);
	endtask
	// Aux restarted under a running primary must land on a primary output
	task automatic t_align();
		int n;
		int k;
		u_core.xfer(1'b1, 8'hD1, 8'h3B);
		wait_pulse(0, 20, n);
		u_core.xfer(1'b1, 8'hE1, 8'h00);
		k = 0;
		for (int i = 0; i < 40 && aux_load !== 1'b1; i++) begin
			@(negedge clk);
			k += (pri_load !== 1'b0);
		end
		chk("aux with primary", 8'h01, {7'h0, pri_load});
		chk("aux wait", 8'h01, {7'h0, k >= 1 && k <= 4});
	endtask
	task automatic t_cal();
		logic [7:0] d;
		int n;
		u_core.xfer(1'b1, 8'hE6, 8'h83);
		chk("reference select", 8'h02, {6'h0, pri_ref_sel});
		chk("primary channel", 8'h03, {4'h0, pri_channel});
		for (int k = 4; k < 8; k++) begin
			u_core.xfer(1'b1, 8'hD1, 8'h28 | k[7:0]);
			chk("short", {7'h0, k == 4}, {7'h0, input_short});
			chk("reference", {7'h0, k == 5}, {7'h0, input_ref});
			chk("kind", k[7:0] & 8'h03, {6'h0, cal_kind});
			chk("chop off", 8'h01, {7'h0, chop_off});
			u_core.read(8'hD8, d);
			chk("ready cleared", 8'h00, d & 8'hC0);
			wait_pulse(2, 30, n);
			chk("cal length", 8'h01, {7'h0, n >= 13 && n <= 17});
			@(negedge clk);
			chk("inputs released", 8'h00, {6'h0, input_short, input_ref});
			u_core.read(8'hD1, d);
			chk("mode after cal", 8'h28, d);
			u_core.read(8'hD8, d);
			chk("ready after cal", 8'h80, d & 8'h80);
		end
	endtask
	task automatic t_temp_cal();
		logic [7:0] d;
		int k;
		u_core.xfer(1'b1, 8'hE1, 8'h2F);
		chk("aux select", 8'h2F, {2'h0, aux_ref_sel, aux_channel});
		u_core.xfer(1'b1, 8'hD1, 8'h1C);
		k = 0;
		repeat (40) begin
			@(negedge clk);
			k += (aux_coef !== 1'b0);
		end
		chk("aux coefficient writes", 8'h00, k[7:0]);
		u_core.read(8'hD8, d);
		chk("aux ready and error", 8'h50, d & 8'h50);
		u_core.read(8'hD1, d);
		chk("mode after aux cal", 8'h18, d);
		u_core.xfer(1'b1, 8'hE1, 8'h20);
		u_core.xfer(1'b1, 8'hD1, 8'h1C);
		wait_pulse(3, 30, k);
		u_core.read(8'hD8, d);
		chk("aux ready after cal", 8'h40, d & 8'h50);
	endtask
	task automatic t_power_down();
		logic [7:0] d;
		int k;
		u_core.xfer(1'b1, 8'hD1, 8'h2B);
		u_core.xfer(1'b1, 8'hC7, 8'h02);
		k = 0;
		repeat (20) begin
			@(negedge clk);
			k += (pri_load !== 1'b0);
		end
		chk("loads while down", 8'h00, k[7:0]);
		u_core.read(8'hD1, d);
		chk("mode kept", 8'h2B, d);
		wake = 1'b1;
		repeat (4) @(negedge clk);
		wake = 1'b0;
		wait_pulse(0, 30, k);
	endtask
	initial begin
		rst_n = 1'b0;
		wake = 1'b0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		t_resets();
		t_convert();
		t_align();
		t_cal();
		t_temp_cal();
		t_power_down();
		wrap_up();
	end
endmodule
`default_nettype wire
